// [rtl/serial_rx_ctrl.sv]
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

// Summary of operation
// - Port enable routes pins, else holds reset
// - Nine-bit select chooses nine or eight bits
// - Sync master single receive, self-clearing
// - Async continuous enable switches receiver
// - Sync continuous receive overrides single
// - Address detect keeps only ninth-bit-set chars
// - No address detect: accept all, ninth visible
// - Address detect ignored eight-bit; zero sync
// - Framing flag follows head of buffer
// - Overrun sticks until continuous enable or port enable cleared
// - Ninth bit presented unchecked to software
// - Eight-bit free-running timer, divisor period
// - High-speed select only in async mode
// - Rate is clock over multiplier times n+1
// - Divisor write clears the timer at once
// - Buffer holds two characters before overrun
// - Clocked mode select picks synchronous operation
// - Sync master clocks from timer, slave external
module serial_rx_ctrl
    import serial_rx_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Receive shift logic and transmitter status
    input wire logic rx_char_valid_i,
    input wire rx_char_t rx_char_i,
    input wire logic tx_shift_empty_i,
    // Control toward the serial datapath
    output logic port_pins_en_o,
    output logic serial_rst_o,
    output logic clocked_mode_o,
    output logic clock_master_o,
    output logic nine_bit_o,
    output logic rx_run_o,
    output logic baud_tick_o,
    output logic rx_ready_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////
    // Bus slave
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic req, wr_en, rd_done;
    logic [7:0] rcv_q, rcv_d, div_q, div_d, txc_q, txc_d;
    logic [7:0] rcv_view, tx_view;
    logic framing_error_flag_head, ninth_head;
    logic overrun_flag_q, overrun_flag_d;
    rx_char_t head;

    assign req = wb_cyc_i & wb_stb_i;
    // Effects land on the edge where the master samples ack
    assign wr_en = req & ack_q & wb_we_i & wb_sel_i[0];
    assign rd_done = req & ack_q & ~wb_we_i;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    assign rcv_view = {rcv_q[7:3], framing_error_flag_head, overrun_flag_q, ninth_head};
    assign tx_view = {txc_q[7:2], tx_shift_empty_i, txc_q[0]};

    always_comb begin
        ack_d = req & ~ack_q;
        rdat_d = rdat_q;
        if (req & ~ack_q) begin
            rdat_d = 32'h0000_0000;
            case (wb_adr_i)
                ADDR_RCV_CTRL: rdat_d[7:0] = rcv_view;
                ADDR_BAUD_DIV: rdat_d[7:0] = div_q;
                ADDR_TX_CTRL: rdat_d[7:0] = tx_view;
                ADDR_RX_DATA: rdat_d[7:0] = head.data;
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers and receive mode
    logic port_en, clocked, master, wr_rcv, wr_div, cont_cleared;
    rx_state_t state_q, state_d;
    logic rx_ev, drop, accept, push, pop, full, ovr_set;

    assign port_en = rcv_q[BIT_PORT_EN];
    assign clocked = txc_q[BIT_CLOCKED];
    assign master = txc_q[BIT_CLK_SRC];
    assign wr_rcv = wr_en & (wb_adr_i == ADDR_RCV_CTRL);
    assign wr_div = wr_en & (wb_adr_i == ADDR_BAUD_DIV);
    assign cont_cleared = wr_rcv & ~wb_dat_i[BIT_CONT];

    always_comb begin
        rcv_d = rcv_q;
        div_d = div_q;
        txc_d = txc_q;
        // Only control bits are stored; flag positions ignore writes
        if (wr_rcv) begin
            rcv_d = wb_dat_i[7:0] & RCV_CTRL_WMASK;
        end
        if (wr_div) begin
            div_d = wb_dat_i[7:0];
        end
        if (wr_en & (wb_adr_i == ADDR_TX_CTRL)) begin
            txc_d = (wb_dat_i[7:0] & TX_CTRL_WMASK) | TX_CTRL_RST;
        end
        // Single receive ends itself after one word
        if (rx_ev & (state_q == RX_SINGLE)) begin
            rcv_d[BIT_SINGLE] = 1'b0;
        end
        state_d = RX_OFF;
        if (!port_en) begin
            state_d = RX_OFF;
        end else if (rcv_q[BIT_CONT]) begin
            state_d = RX_CONT;
        end else if (clocked & master & rcv_q[BIT_SINGLE]) begin
            state_d = RX_SINGLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rcv_q <= RCV_CTRL_RST;
            div_q <= BAUD_DIV_RST;
            txc_q <= TX_CTRL_RST;
            state_q <= RX_OFF;
        end else begin
            rcv_q <= rcv_d;
            div_q <= div_d;
            txc_q <= txc_d;
            state_q <= state_d;
        end
    end

    assign port_pins_en_o = port_en;
    assign serial_rst_o = ~port_en;
    assign clocked_mode_o = clocked;
    assign clock_master_o = clocked & master;
    assign nine_bit_o = rcv_q[BIT_NINE_RX];
    assign rx_run_o = (state_q != RX_OFF);

    ////////////////////////////////////////////////////////////////////
    // Two-entry receive buffer and overrun
    rx_char_t buf_q [2];
    rx_char_t buf_d [2];
    logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [1:0] cnt_q, cnt_d;

    assign rx_ev = rx_char_valid_i & rx_run_o & port_en;
    // Eight-bit and sync reception never filter
    assign drop = ~clocked & rcv_q[BIT_NINE_RX] & rcv_q[BIT_ADDR_DET]
                  & ~rx_char_i.ninth;
    // No further characters while overrun stands
    assign accept = rx_ev & ~drop & ~overrun_flag_q;
    assign pop = rd_done & (wb_adr_i == ADDR_RX_DATA) & (cnt_q != 2'h0);
    assign full = (cnt_q == RX_DEPTH) & ~pop;
    assign push = accept & ~full;
    assign ovr_set = accept & full;
    assign head = buf_q[rd_ptr_q];
    assign framing_error_flag_head = (cnt_q != 2'h0) & head.framing_error_flag;
    assign ninth_head = (cnt_q != 2'h0) & head.ninth;
    assign rx_ready_o = (cnt_q != 2'h0);

    always_comb begin
        buf_d = buf_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        cnt_d = cnt_q;
        overrun_flag_d = overrun_flag_q;
        if (push) begin
            buf_d[wr_ptr_q] = rx_char_i;
            // Ninth bit kept only in nine-bit mode
            buf_d[wr_ptr_q].ninth = rx_char_i.ninth & rcv_q[BIT_NINE_RX];
            wr_ptr_d = ~wr_ptr_q;
        end
        if (pop) begin
            rd_ptr_d = ~rd_ptr_q;
        end
        cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        if (cont_cleared) begin
            overrun_flag_d = 1'b0;
        end
        if (ovr_set) begin
            overrun_flag_d = 1'b1;
        end
        if (!port_en) begin
            wr_ptr_d = 1'b0;
            rd_ptr_d = 1'b0;
            cnt_d = 2'h0;
            overrun_flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
            overrun_flag_q <= 1'b0;
        end else begin
            buf_q <= buf_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q <= cnt_d;
            overrun_flag_q <= overrun_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Baud generator: timer over divisor, then multiplier postscale
    logic [7:0] timer_q, timer_d;
    logic [5:0] post_q, post_d, post_last;
    logic [6:0] mult;
    logic tick_q, tick_d;

    always_comb begin
        if (clocked) begin
            mult = MULT_SYNC;
        end else if (txc_q[BIT_HIGH_SPEED]) begin
            mult = MULT_ASYNC_HIGH;
        end else begin
            mult = MULT_ASYNC_LOW;
        end
        post_last = 6'(mult - 7'h01);
        timer_d = 8'(timer_q + 8'h01);
        post_d = post_q;
        tick_d = 1'b0;
        if (timer_q == div_q) begin
            timer_d = 8'h00;
            post_d = 6'(post_q + 6'h01);
            if (post_q == post_last) begin
                post_d = 6'h00;
                tick_d = 1'b1;
            end
        end
        // Fresh divisor starts from zero, no stale overflow wait
        if (wr_div | ~port_en) begin
            timer_d = 8'h00;
            post_d = 6'h00;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_q <= 8'h00;
            post_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            timer_q <= timer_d;
            post_q <= post_d;
            tick_q <= tick_d;
        end
    end

    assign baud_tick_o = tick_q;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    property p_port_off;
        !port_en |=> (cnt_q == 2'h0) && !overrun_flag_q && !tick_q;
    endproperty
    a_port_off: assert property (p_port_off)
        else $error("port disabled but receive state not reset");
    property p_single_clear;
        (rx_ev && state_q == RX_SINGLE) |=> !rcv_q[BIT_SINGLE];
    endproperty
    a_single_clear: assert property (p_single_clear)
        else $error("single receive not cleared after word");
    property p_cont_state;
        (port_en && rcv_q[BIT_CONT]) |=> state_q == RX_CONT;
    endproperty
    a_cont_state: assert property (p_cont_state)
        else $error("continuous enable did not win");
    property p_addr_drop;
        (rx_ev && drop && !pop && port_en) |=> cnt_q == $past(cnt_q);
    endproperty
    a_addr_drop: assert property (p_addr_drop)
        else $error("non-address character entered buffer");
    property p_ovr_hold;
        (overrun_flag_q && port_en && !cont_cleared) |=> overrun_flag_q;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("overrun cleared without continuous clear");
    property p_ovr_cause;
        $rose(overrun_flag_q) |-> $past(cnt_q) == RX_DEPTH;
    endproperty
    a_ovr_cause: assert property (p_ovr_cause)
        else $error("overrun set with room in buffer");
    property p_timer_range;
        timer_q <= div_q;
    endproperty
    a_timer_range: assert property (p_timer_range)
        else $error("baud timer beyond divisor");
    property p_tick_cause;
        (port_en && !wr_div && timer_q == div_q && post_q == post_last)
        |=> tick_q ##1 !tick_q;
    endproperty
    a_tick_cause: assert property (p_tick_cause)
        else $error("baud tick missing at period end");
    property p_div_clear;
        wr_div |=> (timer_q == 8'h00) && (post_q == 6'h00) && !tick_q;
    endproperty
    a_div_clear: assert property (p_div_clear)
        else $error("divisor write did not clear timer");
    property p_flags_ro;
        (wr_rcv && wb_dat_i[BIT_CONT] && !ovr_set && port_en)
        |=> overrun_flag_q == $past(overrun_flag_q);
    endproperty
    a_flags_ro: assert property (p_flags_ro)
        else $error("write changed read-only overrun flag");
endmodule

// [rtl/serial_rx_pkg.sv]
package serial_rx_pkg;

    // Register byte addresses, one aligned 32-bit word each
    localparam logic [7:0] ADDR_RCV_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BAUD_DIV = 8'h04;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h08;
    localparam logic [7:0] ADDR_RX_DATA = 8'h0C;

    // receive_status_control fields
    localparam int BIT_PORT_EN = 7;
    localparam int BIT_NINE_RX = 6;
    localparam int BIT_SINGLE = 5;
    localparam int BIT_CONT = 4;
    localparam int BIT_ADDR_DET = 3;
    localparam int BIT_FRAMING_ERROR_FLAG = 2;
    localparam int BIT_OVERRUN_FLAG = 1;
    localparam int BIT_NINTH = 0;

    // transmit_status_control fields
    localparam int BIT_CLK_SRC = 7;
    localparam int BIT_CLOCKED = 4;
    localparam int BIT_HIGH_SPEED = 2;
    localparam int BIT_TRMT = 1;

    // Reset values and writable masks
    localparam logic [7:0] RCV_CTRL_RST = 8'h00;
    localparam logic [7:0] RCV_CTRL_WMASK = 8'hF8;
    localparam logic [7:0] BAUD_DIV_RST = 8'h00;
    localparam logic [7:0] TX_CTRL_RST = 8'h02;
    localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;

    // Baud period multipliers
    localparam logic [6:0] MULT_ASYNC_LOW = 7'h40;
    localparam logic [6:0] MULT_ASYNC_HIGH = 7'h10;
    localparam logic [6:0] MULT_SYNC = 7'h04;

    // Receive buffer depth in characters
    localparam logic [1:0] RX_DEPTH = 2'h2;

    typedef struct packed {
        logic framing_error_flag;
        logic ninth;
        logic [7:0] data;
    } rx_char_t;

    typedef enum logic [2:0] {
        RX_OFF = 3'b001,
        RX_SINGLE = 3'b010,
        RX_CONT = 3'b100
    } rx_state_t;

endpackage

// [verif/rx_line_model.sv]
`timescale 1ns/100ps
module rx_line_model
    import serial_rx_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire logic go_i,
    input wire rx_char_t char_i,
    input wire logic [3:0] wait_i,
    // Toward the block
    output logic valid_o,
    output rx_char_t char_o,
    output logic tx_empty_o
);
    logic [3:0] cnt_q = 4'h0;
    logic busy_q = 1'b0;
    rx_char_t last_q = '0;

    ////////////////////////////////////////////////////////////////////////
    // Frame delay, then a one-cycle strobe with the character
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        // Outside the strobe show the inverse, never stale data
        char_o <= ~last_q;
        if (go_i) begin
            busy_q <= 1'b1;
            cnt_q <= wait_i;
            last_q <= char_i;
        end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (busy_q) begin
            valid_o <= 1'b1;
            char_o <= last_q;
            busy_q <= 1'b0;
        end
    end

    assign tx_empty_o = !busy_q;
endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
module tb;
    import serial_rx_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, go_wait;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic valid, tx_empty, go, pins, srst, clocked, master, nine, run;
    logic tick, ready;
    rx_char_t rx_char, go_char;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    logic [7:0] tx_m [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
    int mul [4] = '{64, 16, 4, 4};

    serial_rx_ctrl serial_rx_ctrl_i(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .rx_char_valid_i(valid), .rx_char_i(rx_char),
        .tx_shift_empty_i(tx_empty), .port_pins_en_o(pins),
        .serial_rst_o(srst), .clocked_mode_o(clocked),
        .clock_master_o(master), .nine_bit_o(nine), .rx_run_o(run),
        .baud_tick_o(tick), .rx_ready_o(ready));

    rx_line_model rx_line_model_i(.clk_i, .go_i(go), .char_i(go_char),
        .wait_i(go_wait), .valid_o(valid), .char_o(rx_char),
        .tx_empty_o(tx_empty));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", s, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        // Only the watchdog ends a missing acknowledge
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                       input string s);
        wb(1'b0, a, 8'h00);
        chk(s, rd, {24'h00_0000, e});
    endtask

    task automatic send(input rx_char_t c, input logic [3:0] w);
        @(posedge clk_i);
        go <= 1'b1;
        go_char <= c;
        go_wait <= w;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (w + 4) @(posedge clk_i);
    endtask

    // Bounded wait for the next baud tick, counting edges
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (tick !== 1'b1 && c < 20000);
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        go = 1'b0;
        go_char = '0;
        go_wait = 4'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(ADDR_RCV_CTRL, 8'h00, "rcv reset");
        rdc(ADDR_BAUD_DIV, 8'h00, "div reset");
        rdc(ADDR_TX_CTRL, 8'h02, "tx reset");
        chk("serial rst", srst, 1);
        wb(1'b1, 8'h10, 8'hFF);
        rdc(8'h10, 8'h00, "unmapped");
        wb_sel_i <= 4'hE;
        wb(1'b1, ADDR_BAUD_DIV, 8'h55);
        wb_sel_i <= 4'hF;
        rdc(ADDR_BAUD_DIV, 8'h00, "sel off");
        wb(1'b1, ADDR_RCV_CTRL, 8'h07);
        rdc(ADDR_RCV_CTRL, 8'h00, "ro flags");
        wb(1'b1, ADDR_TX_CTRL, 8'hFF);
        rdc(ADDR_TX_CTRL, 8'hF7, "tx ctrl");
        chk("master", master, 1);
        chk("clocked", clocked, 1);
        $display("test registers done");
        // Slow divisor first, so a missed timer clear shows late
        wb(1'b1, ADDR_RCV_CTRL, 8'h80);
        wb(1'b1, ADDR_BAUD_DIV, 8'hC8);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, ADDR_TX_CTRL, tx_m[i]);
            wb(1'b1, ADDR_BAUD_DIV, 8'h02);
            gap(n);
            chk("first tick", n, mul[i] * 3 + 1);
            gap(n);
            chk("period", n, mul[i] * 3);
        end
        $display("test baud done");
        wb(1'b1, ADDR_TX_CTRL, 8'h04);
        wb(1'b1, ADDR_RCV_CTRL, 8'h98);
        repeat (2) @(posedge clk_i);
        chk("pins", pins, 1);
        chk("serial rst", srst, 0);
        chk("run", run, 1);
        chk("nine", nine, 0);
        send('{1'b1, 1'b1, 8'h3C}, 4'h0);
        chk("ready", ready, 1);
        rdc(ADDR_RCV_CTRL, 8'h9C, "framing_error_flag");
        rdc(ADDR_RX_DATA, 8'h3C, "data");
        @(posedge clk_i);
        chk("empty", ready, 0);
        for (int i = 1; i < 4; i++) send('{1'b0, 1'b0, 8'(i)}, 4'h9);
        rdc(ADDR_RCV_CTRL, 8'h9A, "overrun");
        wb(1'b1, ADDR_RCV_CTRL, 8'h80);
        rdc(ADDR_RCV_CTRL, 8'h80, "ovr clear");
        rdc(ADDR_RX_DATA, 8'h01, "held 1");
        rdc(ADDR_RX_DATA, 8'h02, "held 2");
        chk("run off", run, 0);
        $display("test async done");
        wb(1'b1, ADDR_RCV_CTRL, 8'hD8);
        repeat (2) @(posedge clk_i);
        chk("nine", nine, 1);
        send('{1'b0, 1'b0, 8'h11}, 4'h0);
        chk("filtered", ready, 0);
        send('{1'b0, 1'b1, 8'h55}, 4'h3);
        rdc(ADDR_RCV_CTRL, 8'hD9, "ninth");
        rdc(ADDR_RX_DATA, 8'h55, "addr");
        wb(1'b1, ADDR_RCV_CTRL, 8'hD0);
        send('{1'b0, 1'b0, 8'h66}, 4'h0);
        rdc(ADDR_RCV_CTRL, 8'hD0, "no filter");
        rdc(ADDR_RX_DATA, 8'h66, "all");
        $display("test address done");
        wb(1'b1, ADDR_TX_CTRL, 8'h90);
        wb(1'b1, ADDR_RCV_CTRL, 8'hA0);
        repeat (2) @(posedge clk_i);
        chk("single run", run, 1);
        send('{1'b0, 1'b0, 8'h77}, 4'h2);
        rdc(ADDR_RCV_CTRL, 8'h80, "self clear");
        chk("single off", run, 0);
        rdc(ADDR_RX_DATA, 8'h77, "sync");
        wb(1'b1, ADDR_RCV_CTRL, 8'hB0);
        send('{1'b0, 1'b0, 8'h12}, 4'h2);
        rdc(ADDR_RCV_CTRL, 8'hB0, "cont wins");
        chk("cont run", run, 1);
        rdc(ADDR_RX_DATA, 8'h12, "cont");
        wb(1'b1, ADDR_RCV_CTRL, 8'h00);
        repeat (2) @(posedge clk_i);
        chk("pins off", pins, 0);
        chk("held rst", srst, 1);
        $display("test sync done");
        wrap_up();
    end
endmodule
